// ===== design/sac_control.sv
`timescale 1ns/1ps
`include "sac_params.svh"

module sac_control
   import sac_pkg::*;
#(
   parameter logic [7:0] CONV_TICKS = 8'(`SAC_CONV_TICKS)
)
(
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic [9:0] conv_value,
   output logic            conv_power_on,
   output logic      [2:0] conv_channel,
   output logic            conv_busy,
   output logic            conv_ref_tick,
   output logic            converter_irq,
   output logic      [7:0] port1_analog_route,
   output logic      [7:0] port1_gpio_mode
);

   sac_main_s s;
   sac_main_s next_s;

   logic seq_busy;
   logic seq_done;
   logic ref_tick;

   // One-hot decode of the channel select field
   function automatic logic [7:0] chan_onehot(input logic [2:0] chan);
      logic [7:0] v;
      v = 8'h00;
      v[chan] = 1'b1;
      return v;
   endfunction

   // Read value of the control register from a state copy
   function automatic logic [7:0] ctrl_image(input sac_main_s st);
      logic [7:0] v;
      v = 8'h00;
      v[`SAC_CTRL_IRQ_FLAG]                  = st.irq_flag;
      v[`SAC_CTRL_IRQ_EN]                    = st.irq_en;
      v[`SAC_CTRL_PWR_EN]                    = st.pwr_en;
      v[`SAC_CTRL_CHAN_HI:`SAC_CTRL_CHAN_LO] = st.chan;
      v[`SAC_CTRL_START]                     = st.start;
      v[`SAC_CTRL_DONE]                      = st.done;
      return v;
   endfunction

   // Read value of the prescale register; bits seven to four are reserved
   function automatic logic [7:0] prescale_image(input sac_main_s st);
      logic [7:0] v;
      v = 8'h00;
      v[`SAC_PS_CLK_EN]                    = st.ps_clk_en;
      v[`SAC_PS_CODE_HI:`SAC_PS_CODE_LO]   = st.ps_code;
      return v;
   endfunction

   // Conversion clock enable derived from the oscillator clock
   sac_ref_clock u_ref_clock
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .clk_en  (s.ps_clk_en),
      .code    (s.ps_code),
      .tick    (ref_tick)
   );

   // Conversion timing; a start while the clock is gated simply waits for ticks
   sac_conv_seq #(
      .CONV_TICKS (CONV_TICKS)
   ) u_conv_seq
   (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .power_en (s.pwr_en),
      .start    (s.start),
      .tick     (ref_tick),
      .busy     (seq_busy),
      .done     (seq_done)
   );

   // Next state of the register file and of every registered output
   always_comb
   begin
      next_s = s;

      // The start bit lives for exactly one cycle after the write that set it
      next_s.start = 1'b0;

      // Register writes; the result registers are read-only and ignore writes
      if (sfr_wr)
      begin
         unique case (sfr_addr)
            `SAC_ADDR_PRESCALE:
            begin
               // Only bits three to zero are stored; upper bits are dropped
               next_s.ps_clk_en = sfr_wdata[`SAC_PS_CLK_EN];
               next_s.ps_code   = sfr_wdata[`SAC_PS_CODE_HI:`SAC_PS_CODE_LO];
            end
            `SAC_ADDR_CTRL:
            begin
               next_s.irq_en = sfr_wdata[`SAC_CTRL_IRQ_EN];
               next_s.pwr_en = sfr_wdata[`SAC_CTRL_PWR_EN];
               next_s.chan   = sfr_wdata[`SAC_CTRL_CHAN_HI:`SAC_CTRL_CHAN_LO];
               next_s.start  = sfr_wdata[`SAC_CTRL_START];
               // Flags can only be cleared by software, never set
               if (!sfr_wdata[`SAC_CTRL_DONE])
                  next_s.done = 1'b0;
               if (!sfr_wdata[`SAC_CTRL_IRQ_FLAG])
                  next_s.irq_flag = 1'b0;
            end
            `SAC_ADDR_P1_FUNC:
               next_s.p1_func = sfr_wdata;
            `SAC_ADDR_P1_ALT:
               next_s.p1_alt = sfr_wdata;
            default:
            begin
               next_s.p1_func = s.p1_func;
            end
         endcase
      end

      // An accepted start empties the done flag for the whole conversion
      if (s.start && s.pwr_en && !seq_busy)
         next_s.done = 1'b0;

      // Completion wins over any software clear in the same cycle
      if (seq_done)
      begin
         next_s.result = conv_value;
         next_s.done   = 1'b1;
      end

      // Interrupt flag follows each rise of the done flag; hardware never clears it
      if (next_s.done && !s.done)
         next_s.irq_flag = 1'b1;

      // Interrupt request is registered so the output comes straight from a flop
      next_s.irq = next_s.irq_flag & next_s.irq_en;

      // Pin routing: an analog path only where both selects are set and the channel matches
      next_s.route     = chan_onehot(next_s.chan) & next_s.p1_func & next_s.p1_alt;
      next_s.gpio_mode = ~next_s.p1_func;

      // Read data is captured on the read strobe and held until the next read
      if (sfr_rd)
      begin
         unique case (sfr_addr)
            `SAC_ADDR_PRESCALE:
               next_s.rdata = prescale_image(s);
            `SAC_ADDR_RES_LOW:
               next_s.rdata = s.result[7:0];
            `SAC_ADDR_RES_HIGH:
               next_s.rdata = {6'h00, s.result[9:8]};
            `SAC_ADDR_CTRL:
               next_s.rdata = ctrl_image(s);
            `SAC_ADDR_P1_FUNC:
               next_s.rdata = s.p1_func;
            `SAC_ADDR_P1_ALT:
               next_s.rdata = s.p1_alt;
            default:
               next_s.rdata = 8'h00;
         endcase
      end
   end

   // Single state register; every field has a constant reset value
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s           <= '0;
         s.ps_code   <= 3'(`SAC_RST_PRESCALE);
         s.result    <= `SAC_RST_RESULT;
         s.p1_func   <= `SAC_RST_P1;
         s.p1_alt    <= `SAC_RST_P1;
         s.gpio_mode <= 8'hFF;
      end
      else
         s <= next_s;
   end

   // Outputs come from state flops here or inside the two submodules
   assign sfr_rdata          = s.rdata;
   assign conv_power_on      = s.pwr_en;      // Analog core shut off while low
   assign conv_channel       = s.chan;
   assign conv_busy          = seq_busy;
   assign conv_ref_tick      = ref_tick;
   assign converter_irq      = s.irq;
   assign port1_analog_route = s.route;
   assign port1_gpio_mode    = s.gpio_mode;

endmodule

// ===== design/sac_conv_seq.sv
`timescale 1ns/1ps
`include "sac_params.svh"

// Conversion sequencer: counts conversion clock ticks from start to completion
module sac_conv_seq
   import sac_pkg::*;
#(
   parameter logic [7:0] CONV_TICKS = 8'(`SAC_CONV_TICKS)
)
(
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic power_en,
   input  wire logic start,
   input  wire logic tick,
   output logic      busy,
   output logic      done
);

   sac_seq_s s;
   sac_seq_s next_s;

   // Done is a one-cycle pulse; a start while busy is ignored rather than restarting
   always_comb
   begin
      next_s      = s;
      next_s.done = 1'b0;
      unique case (s.st)
         SAC_SEQ_IDLE:
         begin
            if (start && power_en)
            begin
               next_s.st   = SAC_SEQ_CONVERT;
               next_s.cnt  = 8'h00;
               next_s.busy = 1'b1;
            end
         end
         SAC_SEQ_CONVERT:
         begin
            if (!power_en)
            begin
               next_s.st   = SAC_SEQ_IDLE;
               next_s.busy = 1'b0;
            end
            else if (tick)
            begin
               if (s.cnt == CONV_TICKS - 8'h01)
               begin
                  next_s.st   = SAC_SEQ_IDLE;
                  next_s.busy = 1'b0;
                  next_s.done = 1'b1;
               end
               else
                  next_s.cnt = s.cnt + 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         s <= '{st: SAC_SEQ_IDLE, cnt: 8'h00, busy: 1'b0, done: 1'b0};
      else
         s <= next_s;
   end

   assign busy = s.busy;
   assign done = s.done;

endmodule

// ===== design/sac_params.svh
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// Register addresses on the special-function register bus
`define SAC_ADDR_PRESCALE   8'h94
`define SAC_ADDR_RES_LOW    8'h95
`define SAC_ADDR_RES_HIGH   8'h96
`define SAC_ADDR_CTRL       8'h97
`define SAC_ADDR_P1_FUNC    8'h8E
`define SAC_ADDR_P1_ALT     8'h8F

// Reset values
`define SAC_RST_PRESCALE    8'h00
`define SAC_RST_CTRL        8'h00
`define SAC_RST_RESULT      10'h000
`define SAC_RST_P1          8'h00

// Control register field positions
`define SAC_CTRL_IRQ_FLAG   7
`define SAC_CTRL_IRQ_EN     6
`define SAC_CTRL_PWR_EN     5
`define SAC_CTRL_CHAN_HI    4
`define SAC_CTRL_CHAN_LO    2
`define SAC_CTRL_START      1
`define SAC_CTRL_DONE       0

// Prescale register field positions
`define SAC_PS_CLK_EN       3
`define SAC_PS_CODE_HI      2
`define SAC_PS_CODE_LO      0

// Prescale codes and the last count of each divider
`define SAC_PS_DIV1         3'h0
`define SAC_PS_DIV2         3'h1
`define SAC_PS_DIV4         3'h2
`define SAC_DIV1_LAST       2'h0
`define SAC_DIV2_LAST       2'h1
`define SAC_DIV4_LAST       2'h3

// High result register: bits nine and eight of the result sit in its low two bits
`define SAC_RES_HIGH_BITS   2

// Conversion time, printed as 4 us at an 8 MHz conversion clock
`define SAC_CONV_TIME_NS    4000
`define SAC_CONV_REF_MHZ    8
`define SAC_CONV_TICKS      ((`SAC_CONV_TIME_NS * `SAC_CONV_REF_MHZ) / 1000)

`endif

// ===== design/sac_pkg.sv
package sac_pkg;

   typedef enum logic {SAC_SEQ_IDLE, SAC_SEQ_CONVERT} sac_seq_e;

   // Reference clock prescaler state
   typedef struct packed {
      logic [1:0] cnt;
      logic       tick;
   } sac_pre_s;

   // Conversion sequencer state
   typedef struct packed {
      sac_seq_e   st;
      logic [7:0] cnt;
      logic       busy;
      logic       done;
   } sac_seq_s;

   // Register file and output state of the control block
   typedef struct packed {
      logic       ps_clk_en;
      logic [2:0] ps_code;
      logic       irq_flag;
      logic       irq_en;
      logic       pwr_en;
      logic [2:0] chan;
      logic       start;
      logic       done;
      logic [9:0] result;
      logic [7:0] p1_func;
      logic [7:0] p1_alt;
      logic [7:0] rdata;
      logic       irq;
      logic [7:0] route;
      logic [7:0] gpio_mode;
   } sac_main_s;

endpackage

// ===== design/sac_ref_clock.sv
`timescale 1ns/1ps
`include "sac_params.svh"

// Conversion clock enable: one tick per divided period of the oscillator clock
module sac_ref_clock
   import sac_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   input  wire logic [2:0] code,
   output logic            tick
);

   sac_pre_s s;
   sac_pre_s next_s;
   logic [1:0] last;

   // Last count of the divider; codes outside 0..2 are not allowed, so they fall to the slowest rate
   always_comb
   begin
      unique case (code)
         `SAC_PS_DIV1: last = `SAC_DIV1_LAST;
         `SAC_PS_DIV2: last = `SAC_DIV2_LAST;
         default:      last = `SAC_DIV4_LAST;
      endcase
   end

   // Divider counter; a disabled clock holds the counter at zero and gives no ticks
   always_comb
   begin
      next_s = s;
      if (!clk_en)
      begin
         next_s.cnt  = 2'h0;
         next_s.tick = 1'b0;
      end
      else
      begin
         next_s.tick = (s.cnt == last);
         next_s.cnt  = (s.cnt >= last) ? 2'h0 : s.cnt + 2'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick = s.tick;

endmodule

// ===== tb/sac_analog_model.sv
`timescale 1ns/1ps
// Eight analog pins behind the channel multiplexer
module sac_analog_model
   import sac_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [2:0] conv_channel,
   input  wire logic       conv_busy,
   output logic      [9:0] conv_value
);
   logic [9:0] level;
   logic       busy_q;
   // Each pin has its own level so a wrong route shows
   assign level = {conv_channel[1:0], 5'h15, conv_channel};
   // The result is taken one edge after busy falls, so the value lasts one cycle longer
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         busy_q <= 1'b0;
      else
         busy_q <= conv_busy;
   end
   // Core output is not held outside that window, so an early or late load shows
   assign conv_value = (conv_busy || busy_q) ? level : ~level;
endmodule

// ===== tb/sac_control_sva.sv
`timescale 1ns/1ps
// Port-level checks on the converter control block
module sac_ctl_chk
   import sac_pkg::*;
#(
   parameter logic [7:0] CONV_TICKS = 8'h20
)
(
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [9:0] conv_value,
   input wire logic       conv_power_on,
   input wire logic [2:0] conv_channel,
   input wire logic       conv_busy,
   input wire logic       conv_ref_tick,
   input wire logic       converter_irq,
   input wire logic [7:0] port1_analog_route,
   input wire logic [7:0] port1_gpio_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   logic       wr_ctrl;
   logic       wr_ps;
   logic       wr_ien;
   logic [7:0] tick_cnt;
   assign wr_ctrl = sfr_wr && sfr_addr == 8'h97;
   assign wr_ps = sfr_wr && sfr_addr == 8'h94;
   assign wr_ien = wr_ctrl && sfr_wdata[6];
   // Ticks inside one conversion; cleared while idle so aborts start fresh
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         tick_cnt <= 8'h00;
      else if (!conv_busy)
         tick_cnt <= 8'h00;
      else if (conv_ref_tick)
         tick_cnt <= tick_cnt + 8'h01;
   // Clock gated off and left alone for three cycles
   sequence s_clk_off;
      (wr_ps && !sfr_wdata[3]) ##1 (!wr_ps)[*3];
   endsequence
   a_power_write: assert property (wr_ctrl |=> conv_power_on == $past(sfr_wdata[5]))
      else $error("power enable does not follow control write");
   a_chan_write: assert property (wr_ctrl |=> conv_channel == $past(sfr_wdata[4:2]))
      else $error("channel does not follow control write");
   a_busy_needs_power: assert property ($rose(conv_busy) |-> conv_power_on)
      else $error("conversion started while powered down");
   a_start_busy: assert property (wr_ctrl && (sfr_wdata & 8'h22) == 8'h22 && conv_power_on && !conv_busy
      |-> ##[1:3] conv_busy)
      else $error("start write did not begin a conversion");
   a_conv_ticks: assert property ($fell(conv_busy) && conv_power_on |->
      tick_cnt >= CONV_TICKS - 8'h01 && tick_cnt <= CONV_TICKS + 8'h01)
      else $error("conversion length differs from the tick count");
   a_clk_gate_off: assert property (s_clk_off |-> !conv_ref_tick)
      else $error("reference tick while clock gated off");
   // Completion raises the flag and the request together, one edge after busy falls
   a_irq_cause: assert property ($rose(converter_irq) |->
      ($past(conv_busy, 2) && !$past(conv_busy)) || $past(wr_ien) || $past(wr_ien, 2))
      else $error("interrupt rose without completion or enable");
   a_irq_clear: assert property (wr_ctrl && !sfr_wdata[7] && !conv_busy |-> ##[1:2] !converter_irq)
      else $error("interrupt stays after flag cleared");
   a_route_gpio: assert property ((port1_analog_route & port1_gpio_mode) == 8'h00)
      else $error("pin both routed and general I/O");
endmodule

bind sac_control sac_ctl_chk #(.CONV_TICKS(CONV_TICKS)) chk (.clk_sys, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd,
   .sfr_wdata, .sfr_rdata, .conv_value, .conv_power_on, .conv_channel, .conv_busy, .conv_ref_tick,
   .converter_irq, .port1_analog_route, .port1_gpio_mode);

// ===== tb/sac_control_tb.sv
`timescale 1ns/1ps
module sac_control_tb;
   import sac_pkg::*;
   logic       clk_sys;
   logic       arst_n;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic [9:0] conv_value;
   logic       conv_power_on;
   logic [2:0] conv_channel;
   logic       conv_busy;
   logic       conv_ref_tick;
   logic       converter_irq;
   logic [7:0] port1_analog_route;
   logic [7:0] port1_gpio_mode;
   logic [9:0] exp_val;
   int         fail_count = 0;
   int         checks = 0;
   int         cycles = 0;

   // Short conversion keeps the run brief
   sac_control #(.CONV_TICKS(8'h04)) dut (.clk_sys, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata, .conv_value, .conv_power_on, .conv_channel, .conv_busy, .conv_ref_tick, .converter_irq,
      .port1_analog_route, .port1_gpio_mode);
   sac_analog_model model (.clk_sys, .arst_n, .conv_channel, .conv_busy, .conv_value);

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         tally_and_finish;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One strobe cycle, then a free cycle so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      check({8'h00, sfr_rdata}, {8'h00, exp});
   endtask

   task automatic count_ticks(input logic [7:0] ps, input logic [15:0] exp);
      logic [15:0] k;
      wr(8'h94, ps);
      repeat (4) @(negedge clk_sys);
      k = 16'h0000;
      repeat (16)
      begin
         @(negedge clk_sys);
         k = k + {15'h0000, conv_ref_tick};
      end
      check(k, exp);
   endtask

   task automatic wait_idle;
      int k;
      k = 0;
      while (conv_busy !== 1'b0 && k < 200)
      begin
         @(negedge clk_sys);
         k++;
      end
      // Done flag, result and interrupt land one edge after busy falls
      @(negedge clk_sys);
   endtask

   task automatic convert(input logic [2:0] ch, input logic ien);
      logic [7:0] c;
      c = {1'b0, ien, 1'b1, ch, 2'b00};
      wr(8'h97, c);
      repeat (8) @(negedge clk_sys); // Calibration wait, shortened
      wr(8'h97, c | 8'h02);
      @(negedge clk_sys);
      check({15'h0000, conv_busy}, 16'h0001);
      rd(8'h97, c);
      rd(8'h95, exp_val[7:0]);
      wait_idle;
      exp_val = {ch[1:0], 5'h15, ch};
      check({15'h0000, converter_irq}, {15'h0000, ien});
      rd(8'h97, c | 8'h81);
      rd(8'h95, exp_val[7:0]);
      rd(8'h96, {6'h00, exp_val[9:8]});
   endtask

   initial
   begin
      arst_n = 1'b0;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      exp_val = 10'h000;
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      // Reset values, reserved bits, read-only and unmapped places
      rd(8'h94, 8'h00);
      rd(8'h97, 8'h00);
      rd(8'h90, 8'h00);
      check({8'h00, port1_gpio_mode}, 16'h00FF);
      wr(8'h94, 8'hF2);
      rd(8'h94, 8'h02);
      wr(8'h96, 8'hFF);
      rd(8'h96, 8'h00);
      $display("reset test done");
      // Gate and divider codes; code 2 suits the 40 MHz clock
      count_ticks(8'h02, 16'd0);
      count_ticks(8'h08, 16'd16);
      count_ticks(8'h09, 16'd8);
      count_ticks(8'h0A, 16'd4);
      $display("clock test done");
      // Pin routing for every channel code
      wr(8'h8E, 8'hFF);
      wr(8'h8F, 8'hFF);
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h97, 8'(c << 2));
         @(negedge clk_sys);
         check({port1_gpio_mode, port1_analog_route}, 16'h0001 << c);
         check({13'h0000, conv_channel}, 16'(c));
      end
      wr(8'h8E, 8'h7F);
      @(negedge clk_sys);
      check({port1_gpio_mode, port1_analog_route}, 16'h8000);
      wr(8'h8E, 8'hFF);
      wr(8'h8F, 8'h7F);
      @(negedge clk_sys);
      check({port1_gpio_mode, port1_analog_route}, 16'h0000);
      $display("routing test done");
      // Conversions, flags and interrupt masking
      convert(3'h5, 1'b1);
      wr(8'h97, 8'h74);
      @(negedge clk_sys);
      check({15'h0000, converter_irq}, 16'h0000);
      rd(8'h97, 8'h74);
      convert(3'h7, 1'b0);
      wr(8'h97, 8'hFD);
      @(negedge clk_sys);
      check({15'h0000, converter_irq}, 16'h0001);
      wr(8'h97, 8'h02);
      repeat (6) @(negedge clk_sys);
      check({15'h0000, conv_busy}, 16'h0000);
      rd(8'h97, 8'h00);
      wr(8'h97, 8'h20);
      repeat (6) @(negedge clk_sys);
      check({15'h0000, conv_busy}, 16'h0000);
      check({15'h0000, conv_power_on}, 16'h0001);
      // Power removed mid-conversion aborts it with no completion
      wr(8'h97, 8'h22);
      @(negedge clk_sys);
      check({15'h0000, conv_busy}, 16'h0001);
      wr(8'h97, 8'h00);
      repeat (2) @(negedge clk_sys);
      check({15'h0000, conv_busy}, 16'h0000);
      check({15'h0000, conv_power_on}, 16'h0000);
      rd(8'h97, 8'h00);
      $display("conversion test done");
      tally_and_finish;
   end
endmodule
